// ---- dio_irq_defines.vh ----
`ifndef DIO_IRQ_DEFINES_VH
`define DIO_IRQ_DEFINES_VH

`define CHAN_COUNT 4
`define PORT_COUNT 12
`define WORD_W 24
`define CNT_W 16

// interrupt source codes for each line
`define SRC_NONE 3'h0
`define SRC_COS 3'h1
`define SRC_TIMER 3'h2
`define SRC_EVENT 3'h3
`define SRC_TRIG 3'h4

// counter modes
`define MODE_ONESHOT 3'h0
`define MODE_PERIODIC 3'h2

// reset values
`define DIR_RST 12'h000
`define COS_EN_RST 12'h000
`define SEL_RST 3'h0
`define EDGE_RST 1'b0
`define CNT_RST 16'h0000

`endif

// ---- change_detect.v ----
`include "dio_irq_defines.vh"

module change_detect (
  input wire mclk_i,
  input wire rst_i,
  input wire [23:0] data_i,
  input wire [2:0] enable_i,
  input wire [2:0] is_input_i,
  output reg change_o
);

reg [23:0] prev;
reg primed;
wire [23:0] mask;

assign mask = {{8{enable_i[2] & is_input_i[2]}},
               {8{enable_i[1] & is_input_i[1]}},
               {8{enable_i[0] & is_input_i[0]}}};

////////////////////////////////////////////////////////////////////////////
always @(posedge mclk_i) begin
  if (rst_i) begin
    prev <= 24'h000000;
    primed <= 1'b0;
    change_o <= 1'b0;
  end else begin
    prev <= data_i;
    primed <= 1'b1;
    change_o <= primed & (|((prev ^ data_i) & mask));
  end
end

endmodule // change_detect

// ---- down_counter.v ----
`include "dio_irq_defines.vh"

module down_counter (
  input wire mclk_i,
  input wire rst_i,
  input wire load_i,
  input wire [15:0] value_i,
  input wire periodic_i,
  input wire tick_i,
  output reg [15:0] count_o,
  output reg running_o,
  output reg term_o
);

reg [15:0] reload;
reg periodic;

////////////////////////////////////////////////////////////////////////////
always @(posedge mclk_i) begin
  if (rst_i) begin
    count_o <= `CNT_RST;
    reload <= `CNT_RST;
    periodic <= 1'b0;
    running_o <= 1'b0;
    term_o <= 1'b0;
  end else begin
    term_o <= 1'b0;
    if (load_i) begin
      count_o <= value_i;
      reload <= value_i;
      periodic <= periodic_i;
      running_o <= 1'b1;
    end else if (tick_i && running_o) begin
      if (count_o == 16'h0001) begin
        term_o <= 1'b1;
        count_o <= periodic ? reload : 16'h0000;
        running_o <= periodic;
      end else begin
        count_o <= count_o - 16'h0001;
      end
    end
  end
end

endmodule // down_counter

// ---- dio_irq_timer_ctrl.v ----
`include "dio_irq_defines.vh"

module dio_irq_timer_ctrl (
  input wire mclk_i,
  input wire rst_i,
  input wire sw_reset_i,
  input wire dir_wr_i,
  input wire [11:0] dir_value_i,
  input wire [95:0] port_in_i,
  input wire [1:0] channel_select_i,
  input wire cos_wr_i,
  input wire cos_a_i,
  input wire cos_b_i,
  input wire cos_c_i,
  input wire irq_sel_wr_i,
  input wire [2:0] first_irq_sel_i,
  input wire [2:0] second_irq_sel_i,
  input wire clr_irq_i,
  input wire edge_wr_i,
  input wire edge_value_i,
  input wire event_count_input_i,
  input wire external_trigger_input_i,
  input wire timer_load_i,
  input wire [15:0] timer_one_divider_i,
  input wire [15:0] timer_two_divider_i,
  input wire count0_load_i,
  input wire [2:0] count0_mode_i,
  input wire [15:0] count0_divider_i,
  output reg [11:0] port_dir_o,
  output reg [23:0] chan_word_o,
  output reg [11:0] cos_enable_o,
  output reg edge_select_bit_o,
  output reg trigger_active_o,
  output reg first_irq_line_o,
  output reg second_irq_line_o,
  output reg [1:0] irq_pending_o,
  output reg [3:0] source_pending_o,
  output reg [15:0] count0_o
);

////////////////////////////////////////////////////////////////////////////
// source selection helper
function pick_source;
  input [2:0] sel;
  input [3:0] pend;
  begin
    case (sel)
      `SRC_COS: pick_source = pend[0];
      `SRC_TIMER: pick_source = pend[1];
      `SRC_EVENT: pick_source = pend[2];
      `SRC_TRIG: pick_source = pend[3];
      default: pick_source = 1'b0;
    endcase
  end
endfunction

reg [2:0] first_sel;
reg [2:0] second_sel;
reg event_prev;
reg trig_prev;
reg [3:0] pend;
wire [3:0] change;
wire [11:0] port_is_input;
wire event_edge;
wire trig_now;
wire trig_rise;
wire t1_term;
wire t2_term;
wire c0_term;
wire [15:0] c0_count;
wire [3:0] next_pend;
wire [3:0] src_set;
wire count0_periodic;

assign port_is_input = ~port_dir_o;

////////////////////////////////////////////////////////////////////////////
// port direction
always @(posedge mclk_i) begin
  if (rst_i) begin
    port_dir_o <= `DIR_RST;
  end else begin
    if (sw_reset_i) begin
      port_dir_o <= `DIR_RST;
    end else if (dir_wr_i) begin
      port_dir_o <= dir_value_i;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// change enables per channel
always @(posedge mclk_i) begin
  if (rst_i) begin
    cos_enable_o <= `COS_EN_RST;
  end else begin
    if (cos_wr_i) begin
      cos_enable_o[channel_select_i*3 +: 3] <= {cos_c_i, cos_b_i, cos_a_i};
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// interrupt source selects
always @(posedge mclk_i) begin
  if (rst_i) begin
    first_sel <= `SEL_RST;
    second_sel <= `SEL_RST;
  end else begin
    if (irq_sel_wr_i) begin
      first_sel <= first_irq_sel_i;
      second_sel <= second_irq_sel_i;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// edge select bit
always @(posedge mclk_i) begin
  if (rst_i) begin
    edge_select_bit_o <= `EDGE_RST;
  end else begin
    if (edge_wr_i) begin
      edge_select_bit_o <= edge_value_i;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// change detection per channel
genvar ch;
generate
  for (ch = 0; ch < `CHAN_COUNT; ch = ch + 1) begin : g_chan
    change_detect u_detect (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .data_i(port_in_i[ch*24 +: 24]),
      .enable_i(cos_enable_o[ch*3 +: 3]),
      .is_input_i(port_is_input[ch*3 +: 3]),
      .change_o(change[ch])
    );
  end
endgenerate

////////////////////////////////////////////////////////////////////////////
// channel word readback
always @(posedge mclk_i) begin
  if (rst_i) begin
    chan_word_o <= 24'h000000;
  end else begin
    chan_word_o <= port_in_i[channel_select_i*24 +: 24];
  end
end

////////////////////////////////////////////////////////////////////////////
// event and trigger inputs
// rising at 0, falling at 1
assign event_edge = edge_select_bit_o ? (event_prev & ~event_count_input_i)
                                      : (~event_prev & event_count_input_i);
// active low at 0, high at 1
assign trig_now = edge_select_bit_o ? external_trigger_input_i
                                    : ~external_trigger_input_i;
assign trig_rise = trig_now & ~trig_prev;

always @(posedge mclk_i) begin
  if (rst_i) begin
    event_prev <= 1'b0;
    trig_prev <= 1'b0;
  end else begin
    event_prev <= event_count_input_i;
    trig_prev <= trig_now;
  end
end

////////////////////////////////////////////////////////////////////////////
// trigger level after polarity
always @(posedge mclk_i) begin
  if (rst_i) begin
    trigger_active_o <= 1'b0;
  end else begin
    trigger_active_o <= trig_now;
  end
end

////////////////////////////////////////////////////////////////////////////
// counters
// counter two counts counter one ends
down_counter u_timer_one (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .load_i(timer_load_i),
  .value_i(timer_one_divider_i),
  .periodic_i(1'b1),
  .tick_i(1'b1),
  .count_o(),
  .running_o(),
  .term_o(t1_term)
);

// ticks once per counter one end
down_counter u_timer_two (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .load_i(timer_load_i),
  .value_i(timer_two_divider_i),
  .periodic_i(1'b1),
  .tick_i(t1_term),
  .count_o(),
  .running_o(),
  .term_o(t2_term)
);

////////////////////////////////////////////////////////////////////////////
// counter zero
// mode code picks reload
assign count0_periodic = (count0_mode_i == `MODE_PERIODIC);

down_counter u_count_zero (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .load_i(count0_load_i),
  .value_i(count0_divider_i),
  .periodic_i(count0_periodic),
  .tick_i(event_edge),
  .count_o(c0_count),
  .running_o(),
  .term_o(c0_term)
);

////////////////////////////////////////////////////////////////////////////
// counter zero readback
always @(posedge mclk_i) begin
  if (rst_i) begin
    count0_o <= `CNT_RST;
  end else begin
    count0_o <= c0_count;
  end
end

////////////////////////////////////////////////////////////////////////////
// pending requests per source
assign src_set = {trig_rise, c0_term, t2_term, |change};
assign next_pend = src_set | (clr_irq_i ? 4'h0 : pend);

always @(posedge mclk_i) begin
  if (rst_i) begin
    pend <= 4'h0;
    source_pending_o <= 4'h0;
  end else begin
    pend <= next_pend;
    source_pending_o <= next_pend;
  end
end

////////////////////////////////////////////////////////////////////////////
// interrupt lines
always @(posedge mclk_i) begin
  if (rst_i) begin
    first_irq_line_o <= 1'b0;
    second_irq_line_o <= 1'b0;
    irq_pending_o <= 2'b00;
  end else begin
    first_irq_line_o <= pick_source(first_sel, next_pend);
    second_irq_line_o <= pick_source(second_sel, next_pend);
    irq_pending_o <= {pick_source(second_sel, next_pend),
                      pick_source(first_sel, next_pend)};
  end
end

endmodule // dio_irq_timer_ctrl

// ---- dio_props.sv ----
module dio_props (
  input wire mclk_i, rst_i, sw_reset_i, cos_wr_i, cos_a_i, cos_b_i,
  input wire cos_c_i, clr_irq_i, external_trigger_input_i,
  input wire edge_select_bit_o, trigger_active_o,
  input wire first_irq_line_o, second_irq_line_o,
  input wire [1:0] channel_select_i, irq_pending_o,
  input wire [3:0] source_pending_o,
  input wire [11:0] port_dir_o, cos_enable_o,
  input wire [15:0] count0_o,
  input wire [23:0] chan_word_o,
  input wire [95:0] port_in_i
);
  timeunit 1ns;
  timeprecision 100ps;
  wire [23:0] pick = port_in_i[channel_select_i*24+:24];
  wire [2:0] abc = {cos_c_i, cos_b_i, cos_a_i};
  wire act = external_trigger_input_i ~^ edge_select_bit_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_swr_dir: assert property (sw_reset_i |=> port_dir_o == 12'h000)
    else $error("dir kept");
  a_swr_keep: assert property (sw_reset_i && !cos_wr_i |=>
    $stable(cos_enable_o)) else $error("enables lost");
  a_line_pend: assert property (
    irq_pending_o == {second_irq_line_o, first_irq_line_o})
    else $error("pending differs");
  a_cos_en: assert property (cos_wr_i |=>
    cos_enable_o[$past(channel_select_i)*3+:3] == $past(abc))
    else $error("enable bad");
  a_trig_pol: assert property (1 |=> trigger_active_o == $past(act))
    else $error("polarity bad");
  a_word_map: assert property (1 |=> chan_word_o == $past(pick))
    else $error("word bad");
  a_pend_sticky: assert property (!clr_irq_i |=>
    (source_pending_o | $past(source_pending_o)) == source_pending_o)
    else $error("pending dropped");
  a_rst_state: assert property ($fell(rst_i) |->
    cos_enable_o == 12'h000 && count0_o == 16'h0000)
    else $error("reset state bad");
  cover property (first_irq_line_o);
  cover property (second_irq_line_o);
  cover property (sw_reset_i);
endmodule // dio_props
bind dio_irq_timer_ctrl dio_props props (.*);

// ---- field_model.sv ----
module field_model (
  input wire mclk_i,
  input wire [11:0] dir_i,
  input wire [95:0] pat_i,
  output logic [95:0] pins_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tg = 1'b0;
  always @(posedge mclk_i) tg <= ~tg;
  always_comb
    for (int k = 0; k < 12; k++)
      pins_o[k*8+:8] = dir_i[k] ? {8{tg}} : pat_i[k*8+:8];
endmodule // field_model

// ---- testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 0, rst_i = 1, sw_reset_i = 0, dir_wr_i = 0, cos_wr_i = 0;
  logic cos_a_i = 0, cos_b_i = 0, cos_c_i = 0, irq_sel_wr_i = 0;
  logic clr_irq_i = 0, edge_wr_i = 0, edge_value_i = 0;
  logic event_count_input_i = 0, external_trigger_input_i = 1;
  logic timer_load_i = 0, count0_load_i = 0;
  logic [1:0] channel_select_i = 0;
  logic [2:0] first_irq_sel_i = 0, second_irq_sel_i = 0, count0_mode_i = 0;
  logic [11:0] dir_value_i = 0;
  logic [15:0] timer_one_divider_i = 0, timer_two_divider_i = 0;
  logic [15:0] count0_divider_i = 0;
  logic [95:0] pat = 0;
  wire [95:0] port_in_i;
  wire [11:0] port_dir_o, cos_enable_o;
  wire [23:0] chan_word_o;
  wire edge_select_bit_o, trigger_active_o;
  wire first_irq_line_o, second_irq_line_o;
  wire [1:0] irq_pending_o;
  wire [3:0] source_pending_o;
  wire [15:0] count0_o;
  logic [31:0] r = 32'h4b9d3aa3;
  logic [23:0] qe[$];
  int qs[$];
  int n_fail = 0, cmp_count = 0;
  dio_irq_timer_ctrl dut (.*);
  field_model fm (.mclk_i(mclk_i), .dir_i(port_dir_o), .pat_i(pat),
    .pins_o(port_in_i));
  ////////////////////////////////////////
  function [31:0] lf(input [31:0] s);
    lf = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [23:0] obs(int s);
    case (s)
      0: obs = port_dir_o;
      1: obs = cos_enable_o;
      2: obs = source_pending_o;
      3: obs = irq_pending_o;
      5: obs = edge_select_bit_o;
      6: obs = chan_word_o;
      default: obs = count0_o;
    endcase
  endfunction
  task chk(input [23:0] g, e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task ex(int s, input [23:0] e);
    qs.push_back(s);
    qe.push_back(e);
  endtask
  task st(int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic pu(ref logic s);
    s = 1;
    st(1);
    s = 0;
  endtask
  task tally_and_finish;
    $display("fails=%0d compares=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  always @(posedge mclk_i)
    if (qs.size())
      chk(obs(qs.pop_front()), qe.pop_front());
  initial forever #5 mclk_i = ~mclk_i;
  initial begin
    #20000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    st(4);
    rst_i = 0;
    ex(1, 24'h0);
    r = lf(r);
    dir_value_i = r[11:0];
    pu(dir_wr_i);
    ex(0, r[11:0]);
    channel_select_i = 2'h2;
    {cos_c_i, cos_b_i, cos_a_i} = 3'h5;
    pu(cos_wr_i);
    pu(sw_reset_i);
    ex(0, 24'h0);
    st(1);
    ex(1, 24'h140);
    st(4);
    first_irq_sel_i = 3'h1;
    second_irq_sel_i = 3'h5;
    pu(irq_sel_wr_i);
    pu(clr_irq_i);
    pat[56] = 1;
    st(4);
    ex(2, 24'h0);
    pat[64] = 1;
    st(4);
    ex(2, 24'h1);
    st(1);
    ex(3, 24'h1);
    st(2);
    ex(6, 24'h010100);
    pu(clr_irq_i);
    ex(3, 24'h0);
    first_irq_sel_i = 3'h3;
    second_irq_sel_i = 3'h2;
    pu(irq_sel_wr_i);
    count0_divider_i = 16'h0003;
    pu(count0_load_i);
    for (int k = 2; k >= 0; k--) begin
      event_count_input_i = 1;
      st(2);
      event_count_input_i = 0;
      st(2);
      ex(4, 24'(k));
    end
    st(2);
    ex(2, 24'h4);
    st(1);
    ex(3, 24'h1);
    st(2);
    pu(clr_irq_i);
    timer_one_divider_i = 16'h0004;
    timer_two_divider_i = 16'h0005;
    pu(timer_load_i);
    st(12);
    ex(2, 24'h0);
    st(14);
    ex(2, 24'h2);
    st(1);
    ex(3, 24'h2);
    st(1);
    first_irq_sel_i = 3'h4;
    second_irq_sel_i = 3'h5;
    pu(irq_sel_wr_i);
    edge_value_i = 1;
    pu(edge_wr_i);
    ex(5, 24'h1);
    st(3);
    ex(3, 24'h1);
    st(3);
    first_irq_sel_i = 3'h3;
    second_irq_sel_i = 3'h5;
    pu(irq_sel_wr_i);
    pu(clr_irq_i);
    count0_mode_i = 3'h2;
    count0_divider_i = 16'h0002;
    pu(count0_load_i);
    for (int k = 1; k <= 4; k++) begin
      event_count_input_i = 1;
      st(2);
      event_count_input_i = 0;
      st(2);
      ex(4, 24'(2 - k % 2));
    end
    st(1);
    ex(3, 24'h1);
    st(3);
    tally_and_finish;
  end
endmodule // testbench
